// ### logic/swl_fifo.sv
// Purpose: Small valid/ready FIFO.
// Assumes: One clock domain.
// Notes: Full and empty are exact.
`timescale 1ns/1ps
module swl_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic do_wr, do_rd;
  logic next_ready;
  always_comb begin
    out_valid_o = wr_ptr != rd_ptr;
    out_data_o = mem[rd_ptr[AW-1:0]];
    do_wr = in_valid_i && in_ready_o;
    do_rd = out_valid_o && out_ready_i;
    next_wr_ptr = wr_ptr + (AW+1)'(do_wr);
    next_rd_ptr = rd_ptr + (AW+1)'(do_rd);
    // Ready is taken from the next fill level so that the port comes from a flip-flop.
    next_ready = (next_wr_ptr - next_rd_ptr) != (AW+1)'(DEPTH);
  end
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      in_ready_o <= 1'b0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      in_ready_o <= next_ready;
    end
  end
  always_ff @(posedge clk_i) begin
    if (do_wr) begin
      mem[wr_ptr[AW-1:0]] <= in_data_i;
    end
  end
endmodule

// ### logic/swl_master.sv
// Purpose: Front-end master end of the single-wire link.
// Assumes: Core clock clk_i; the bit clock is made here by a divider.
// Notes: Operation
`timescale 1ns/1ps
module swl_master
  import swl_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic enable_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  input wire logic [swl_pkg::BYTE_W-1:0] tx_data_i,
  output logic rx_valid_o,
  output logic [swl_pkg::BYTE_W-1:0] rx_data_o,
  output logic active_o,
  swl_if.frontend_master link
);
  import swl_pkg::*;
  // only sys_rst_i resets this end
  ////////////////////////////////////////////////////////////////////////////
  // Transmit buffer.
  logic fifo_valid, fifo_pop;
  logic [BYTE_W-1:0] fifo_data;
  swl_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .in_valid_i(tx_valid_i),
    .in_ready_o(tx_ready_o),
    .in_data_i(tx_data_i),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_pop),
    .out_data_o(fifo_data)
  );
  ////////////////////////////////////////////////////////////////////////////
  // Bit timing and downlink state.
  swl_mstate_t state, next_state;
  logic [CNT_W-1:0] phase, next_phase;
  logic [BYTE_W-1:0] shreg, next_shreg;
  logic [BIT_IDX_W-1:0] bit_idx, next_bit_idx;
  logic in_frame, next_in_frame;
  logic cur_bit, next_cur_bit;
  logic s1, next_s1;
  logic up_smp, next_up_smp;
  logic [2:0] up_sync, next_up_sync;
  logic [BYTE_W-1:0] rx_sh, next_rx_sh;
  logic [BIT_IDX_W-1:0] rx_cnt, next_rx_cnt;
  logic rx_v, next_rx_v;
  logic [BYTE_W-1:0] rx_d, next_rx_d;
  logic act, next_act;
  logic bit_end;
  always_comb begin
    next_state = state;
    next_phase = phase;
    next_shreg = shreg;
    next_bit_idx = bit_idx;
    next_in_frame = in_frame;
    next_cur_bit = cur_bit;
    next_up_smp = up_smp;
    next_up_sync = {up_sync[1:0], link.uplink_current_signal};
    next_rx_sh = rx_sh;
    next_rx_cnt = rx_cnt;
    next_rx_v = 1'b0;
    next_rx_d = rx_d;
    next_act = act;
    fifo_pop = 1'b0;
    next_s1 = 1'b0;
    bit_end = phase == CNT_W'(BIT_CYC - 1);
    unique case (state)
      SWL_OFF: begin
        next_phase = '0;
        next_act = 1'b0;
        if (enable_i) begin
          next_state = SWL_RESUME;
          next_cur_bit = 1'b0;
        end
      end
      SWL_RESUME: begin
        next_phase = phase + CNT_W'(1);
        if (phase == CNT_W'(BIT_CYC - HIGH_ZERO_CYC - 1)) begin
          next_state = SWL_RUN;
          next_phase = '0;
          next_act = 1'b1;
          // The first bit opens with its full high phase as resume ends.
          next_s1 = 1'b1;
        end
      end
      SWL_RUN: begin
        next_phase = bit_end ? '0 : phase + CNT_W'(1);
        next_s1 = cur_bit ? (next_phase < CNT_W'(HIGH_ONE_CYC)) : (next_phase < CNT_W'(HIGH_ZERO_CYC));
        if (s1 && phase == CNT_W'(HIGH_ZERO_CYC - 1) && up_sync[1] == up_sync[2]) begin
          next_up_smp = up_sync[2];
        end
        if (bit_end) begin
          next_rx_sh = {rx_sh[BYTE_W-2:0], up_smp};
          next_rx_cnt = rx_cnt + BIT_IDX_W'(1);
          if (rx_cnt == MSB_IDX) begin
            next_rx_v = 1'b1;
            next_rx_d = {rx_sh[BYTE_W-2:0], up_smp};
          end
          if (in_frame && bit_idx != LSB_IDX) begin
            next_bit_idx = bit_idx - BIT_IDX_W'(1);
            next_cur_bit = shreg[bit_idx - BIT_IDX_W'(1)];
          end else if (fifo_valid) begin
            fifo_pop = 1'b1;
            next_in_frame = 1'b1;
            next_shreg = fifo_data;
            next_bit_idx = MSB_IDX;
            next_cur_bit = fifo_data[MSB_IDX];
          end else begin
            next_in_frame = 1'b0;
            next_cur_bit = 1'b0;
          end
        end
        if (!enable_i) begin
          next_state = SWL_OFF;
          next_s1 = 1'b0;
          next_in_frame = 1'b0;
        end
      end
      default: next_state = SWL_OFF;
    endcase
  end
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state <= SWL_OFF;
      phase <= '0;
      shreg <= '0;
      bit_idx <= '0;
      in_frame <= 1'b0;
      cur_bit <= 1'b0;
      s1 <= 1'b0;
      up_smp <= 1'b0;
      up_sync <= '0;
      rx_sh <= '0;
      rx_cnt <= '0;
      rx_v <= 1'b0;
      rx_d <= '0;
      act <= 1'b0;
    end else begin
      state <= next_state;
      phase <= next_phase;
      shreg <= next_shreg;
      bit_idx <= next_bit_idx;
      in_frame <= next_in_frame;
      cur_bit <= next_cur_bit;
      s1 <= next_s1;
      up_smp <= next_up_smp;
      up_sync <= next_up_sync;
      rx_sh <= next_rx_sh;
      rx_cnt <= next_rx_cnt;
      rx_v <= next_rx_v;
      rx_d <= next_rx_d;
      act <= next_act;
    end
  end
  assign link.downlink_voltage_signal = s1;
  assign rx_valid_o = rx_v;
  assign rx_data_o = rx_d;
  assign active_o = act;
endmodule

// ### logic/swl_slave.sv
// Purpose: Card slave end of the single-wire link.
// Assumes: Uplink clocked by the downlink itself as the link clock; receive side clocked by ref_clk_i.
// Notes: Bits are recovered by high-time against a period-derived threshold.
`timescale 1ns/1ps
module swl_slave
  import swl_pkg::*;
(
  input wire logic link_clk_i,
  input wire logic sys_rst_i,
  input wire logic ref_clk_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  input wire logic [swl_pkg::BYTE_W-1:0] tx_data_i,
  output logic rx_valid_o,
  output logic [swl_pkg::BYTE_W-1:0] rx_data_o,
  swl_if.card_slave link
);
  import swl_pkg::*;
  // link state uses only its own reset
  ////////////////////////////////////////////////////////////////////////////
  // High-time measurement on a fast reference clock with a 3-stage sync.
  logic [2:0] sync, next_sync;
  logic [MEAS_W-1:0] hi_cnt, next_hi_cnt, lo_cnt, next_lo_cnt;
  logic dl_f, next_dl_f;
  logic [BYTE_W-1:0] rx_sh, next_rx_sh;
  logic [BIT_IDX_W-1:0] rx_cnt, next_rx_cnt;
  logic rx_v, next_rx_v;
  logic [BYTE_W-1:0] rx_d, next_rx_d;
  logic rise, bit_val;
  always_comb begin
    next_sync = {sync[1:0], link.downlink_voltage_signal};
    next_hi_cnt = hi_cnt;
    next_lo_cnt = lo_cnt;
    next_dl_f = dl_f;
    next_rx_sh = rx_sh;
    next_rx_cnt = rx_cnt;
    next_rx_v = 1'b0;
    next_rx_d = rx_d;
    // A level change counts only once the second and third stages agree.
    rise = sync[1] && sync[2] && !dl_f;
    bit_val = hi_cnt > lo_cnt;
    if (sync[1] == sync[2]) begin
      next_dl_f = sync[2];
      if (sync[2]) begin
        next_hi_cnt = hi_cnt + MEAS_W'(1);
      end else begin
        next_lo_cnt = lo_cnt + MEAS_W'(1);
      end
    end
    if (rise) begin
      next_rx_sh = {rx_sh[BYTE_W-2:0], bit_val};
      next_rx_cnt = rx_cnt + BIT_IDX_W'(1);
      if (rx_cnt == MSB_IDX) begin
        next_rx_v = 1'b1;
        next_rx_d = {rx_sh[BYTE_W-2:0], bit_val};
      end
      next_hi_cnt = '0;
      next_lo_cnt = '0;
    end
  end
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sync <= '0;
      hi_cnt <= '0;
      lo_cnt <= '0;
      dl_f <= 1'b0;
      rx_sh <= '0;
      rx_cnt <= '0;
      rx_v <= 1'b0;
      rx_d <= '0;
    end else begin
      sync <= next_sync;
      hi_cnt <= next_hi_cnt;
      lo_cnt <= next_lo_cnt;
      dl_f <= next_dl_f;
      rx_sh <= next_rx_sh;
      rx_cnt <= next_rx_cnt;
      rx_v <= next_rx_v;
      rx_d <= next_rx_d;
    end
  end
  assign rx_valid_o = rx_v;
  assign rx_data_o = rx_d;
  ////////////////////////////////////////////////////////////////////////////
  // Uplink on the link clock: wakeup then byte, MSB first.
  swl_ustate_t ust, next_ust;
  logic [BYTE_W-1:0] tsh, next_tsh;
  logic [BIT_IDX_W-1:0] tcnt, next_tcnt;
  logic s2, next_s2;
  logic rdy, next_rdy;
  always_comb begin
    next_ust = ust;
    next_tsh = tsh;
    next_tcnt = tcnt;
    next_s2 = 1'b0;
    unique case (ust)
      SWL_U_IDLE: begin
        if (tx_valid_i && rdy) begin
          next_tsh = tx_data_i | RESERVED_FILL;
          next_ust = SWL_U_WAKE;
          next_tcnt = '0;
        end
      end
      SWL_U_WAKE: begin
        next_s2 = 1'b1;
        next_tcnt = tcnt + BIT_IDX_W'(1);
        if (tcnt == WAKE_BITS - BIT_IDX_W'(1)) begin
          next_ust = SWL_U_DATA;
          next_tcnt = MSB_IDX;
        end
      end
      SWL_U_DATA: begin
        next_s2 = tsh[tcnt];
        next_tcnt = tcnt - BIT_IDX_W'(1);
        if (tcnt == LSB_IDX) begin
          next_ust = SWL_U_IDLE;
        end
      end
      default: next_ust = SWL_U_IDLE;
    endcase
    // Ready is registered so that the port comes from a flip-flop.
    next_rdy = next_ust == SWL_U_IDLE;
  end
  // Link clock is the downlink's rising edge; uplink changes there and is read while high.
  always_ff @(posedge link_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ust <= SWL_U_IDLE;
      tsh <= '0;
      tcnt <= '0;
      s2 <= 1'b0;
      rdy <= 1'b0;
    end else begin
      ust <= next_ust;
      tsh <= next_tsh;
      tcnt <= next_tcnt;
      s2 <= next_s2;
      rdy <= next_rdy;
    end
  end
  assign link.uplink_current_signal = s2;
  assign tx_ready_o = rdy;
endmodule

// ### pkg/swl_if.sv
// Purpose: Single wire between front-end master and card slave.
// Assumes: Master drives the voltage level, slave drives a current level.
// Notes: Both levels travel on separate nets; the bench models the wire.
`timescale 1ns/1ps
interface swl_if;
  logic downlink_voltage_signal;
  logic uplink_current_signal;
  modport frontend_master (output downlink_voltage_signal, input uplink_current_signal);
  modport card_slave (input downlink_voltage_signal, output uplink_current_signal);
endinterface

// ### pkg/swl_pkg.sv
// Purpose: Shared constants and types for the single-wire link ends.
// Assumes: Master core clock 200 MHz; the bit clock is derived by a divider.
// Notes: Bit times are counted in core clock cycles.
package swl_pkg;
  localparam int unsigned CLK_PERIOD_PS = 5000;
  // Bit period and high-phase lengths in nanoseconds.
  localparam int unsigned BIT_TIME_NS = 100;
  localparam int unsigned HIGH_ONE_NS = 75;
  localparam int unsigned HIGH_ZERO_NS = 25;
  localparam int unsigned BIT_CYC = (BIT_TIME_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned HIGH_ONE_CYC = (HIGH_ONE_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned HIGH_ZERO_CYC = (HIGH_ZERO_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned CNT_W = 8;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned BIT_IDX_W = 3;
  localparam logic [BIT_IDX_W-1:0] MSB_IDX = 3'h7;
  localparam logic [BIT_IDX_W-1:0] LSB_IDX = 3'h0;
  localparam int unsigned FIFO_DEPTH = 8;
  // Slave wakeup prefix: idle-one pattern bits before each uplink byte.
  localparam logic [BIT_IDX_W-1:0] WAKE_BITS = 3'h2;
  localparam logic [BYTE_W-1:0] RESERVED_FILL = 8'h00;
  // Reference-clock counter width for recovering bits at the slave.
  localparam int unsigned MEAS_W = 8;
  typedef enum logic [1:0] {SWL_OFF, SWL_RESUME, SWL_RUN} swl_mstate_t;
  typedef enum logic [1:0] {SWL_U_IDLE, SWL_U_WAKE, SWL_U_DATA} swl_ustate_t;
endpackage

// ### tb/single_wire_link_core_tb_top.sv
// Purpose: Joins both link ends and checks the streams at wire and user sides.
// Assumes: The slave reference clock is the master core clock.
// Notes: Downlink bytes carry b8 set, so idle zeros frame them on the wire.
`timescale 1ns/1ps
`define CHK(a, b, m) begin n_tests++; if ((a) !== (b)) begin n_errors++; $display("BAD %0t %s", $time, m); end end
module single_wire_link_core_tb_top;
  import swl_pkg::*;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic en = 1'b0;
  logic m_tv = 1'b0;
  logic s_tv = 1'b0;
  logic [7:0] m_td = 8'h00;
  logic [7:0] s_td = 8'h00;
  logic m_tr, m_rv, act, s_tr, s_rv;
  logic [7:0] m_rd, s_rd, dh, uh, db, ub;
  logic [7:0] q_dn[$];
  logic [7:0] q_up[$];
  int n_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  int hc, ds, us;
  swl_if lnk();
  swl_master swl_master_inst(.clk_i, .sys_rst_i, .enable_i(en), .tx_valid_i(m_tv), .tx_ready_o(m_tr),
    .tx_data_i(m_td), .rx_valid_o(m_rv), .rx_data_o(m_rd), .active_o(act), .link(lnk));
  swl_slave swl_slave_inst(.link_clk_i(lnk.downlink_voltage_signal), .sys_rst_i, .ref_clk_i(clk_i),
    .tx_valid_i(s_tv), .tx_ready_o(s_tr), .tx_data_i(s_td), .rx_valid_o(s_rv), .rx_data_o(s_rd), .link(lnk));
  swl_chk swl_chk_inst(.clk_i, .sys_rst_i, .downlink_voltage_signal(lnk.downlink_voltage_signal),
    .uplink_current_signal(lnk.uplink_current_signal));
  initial forever #2.5 clk_i = ~clk_i;
  ////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic start_link();
    int w;
    w = 0;
    @(posedge clk_i);
    #1 sys_rst_i = 1'b1;
    en = 1'b0;
    repeat (20) @(posedge clk_i);
    #1 sys_rst_i = 1'b0;
    q_dn.delete();
    q_up.delete();
    @(posedge clk_i);
    #1 en = 1'b1;
    while (act !== 1'b1 && w < 40) begin
      @(posedge clk_i);
      w++;
    end
    `CHK(w >= BIT_CYC - HIGH_ZERO_CYC && w < 40, 1'b1, "resume")
    $display("test start done");
  endtask
  task automatic m_send(input logic [7:0] d, output int w);
    w = 0;
    @(posedge clk_i);
    #1 m_tv = 1'b1;
    m_td = d;
    q_dn.push_back(d);
    do begin
      @(posedge clk_i);
      w++;
    end while (m_tr !== 1'b1);
    #1 m_tv = 1'b0;
  endtask
  // The slave side is clocked by the downlink, so it is driven from that wire.
  task automatic s_send(input logic [7:0] d);
    @(posedge lnk.downlink_voltage_signal);
    #1 s_tv = 1'b1;
    s_td = d;
    q_up.push_back(d);
    do @(negedge lnk.downlink_voltage_signal); while (s_tr !== 1'b1);
    @(posedge lnk.downlink_voltage_signal);
    #1 s_tv = 1'b0;
  endtask
  task automatic drain(input string t);
    int w;
    w = 0;
    while ((q_dn.size() || q_up.size()) && w < 6000) begin
      @(posedge clk_i);
      w++;
    end
    `CHK(q_dn.size() + q_up.size(), 0, "bytes lost")
    $display("test %s done", t);
  endtask
  task automatic dl_bit(input int h);
    logic [7:0] e;
    logic b;
    b = h > BIT_CYC / 2;
    `CHK(h == HIGH_ONE_CYC || h == HIGH_ZERO_CYC, 1'b1, "high time")
    dh = {dh[6:0], b};
    if (ds > 0 || b) begin
      db = {db[6:0], b};
      ds++;
    end
    if (ds == 8) begin
      e = q_dn.pop_front();
      `CHK(db, e, "downlink byte")
      ds = 0;
    end
  endtask
  task automatic up_bit(input logic b);
    logic [7:0] e;
    uh = {uh[6:0], b};
    if (us == 1) `CHK(b, 1'b1, "wakeup")
    if (us > 1) ub = {ub[6:0], b};
    if (us > 0 || b === 1'b1) us++;
    if (us == 10) begin
      e = q_up.pop_front();
      `CHK(ub, e, "uplink byte")
      us = 0;
    end
  endtask
  // Watches the wire and both receive sides on every rising core clock edge.
  always @(posedge clk_i) begin
    cyc++;
    if (cyc > 40000) begin
      n_errors++;
      stop_test();
    end
    if (sys_rst_i) begin
      {hc, ds, us} = '0;
      {dh, uh} = 16'h0000;
    end else begin
      if (s_rv === 1'b1) `CHK(s_rd, dh, "slave rx")
      if (m_rv === 1'b1) `CHK(m_rd, uh, "master rx")
      if (lnk.downlink_voltage_signal) hc++;
      else begin
        if (hc > 0) dl_bit(hc);
        hc = 0;
      end
      if (hc == 2) up_bit(lnk.uplink_current_signal);
    end
  end
  initial begin
    int ws[10];
    void'($urandom(32'hbafa_f557));
    start_link();
    repeat (400) @(posedge clk_i);
    $display("test idle done");
    fork
      for (int i = 0; i < 10; i++) m_send(8'($urandom) | 8'h80, ws[i]);
      begin
        s_send(8'h00);
        s_send(8'hff);
        repeat (3) s_send(8'($urandom));
      end
    join
    for (int i = 0; i < 8; i++) `CHK(ws[i], 1, "refused early")
    `CHK(ws[9] > 1, 1'b1, "full not refused")
    drain("duplex");
    start_link();
    m_send(8'hc5, ws[0]);
    s_send(8'h3a);
    drain("reset");
    stop_test();
  end
endmodule

// ### tb/swl_chk.sv
// Purpose: Wire checks for the single-wire link.
// Assumes: Both wire levels are sampled on the master core clock.
// Notes: Run lengths are in core clock cycles.
`timescale 1ns/1ps
module swl_chk
  import swl_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic downlink_voltage_signal,
  input wire logic uplink_current_signal
);
  wire dl = downlink_voltage_signal;
  logic [7:0] hi_len;
  logic [7:0] lo_len;
  logic [7:0] since;
  logic seen;
  // The lo_len and since counts saturate so that a long idle cannot wrap round.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hi_len <= 8'h00;
      lo_len <= 8'h00;
      since <= 8'h00;
      seen <= 1'b0;
    end else begin
      hi_len <= dl ? hi_len + 8'h01 : 8'h00;
      lo_len <= dl ? 8'h00 : lo_len + {7'h00, lo_len != 8'hff};
      since <= $rose(dl) ? 8'h01 : since + {7'h00, since != 8'hff};
      seen <= seen | $rose(dl);
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);
  a_high_width: assert property ($fell(dl) |-> hi_len == HIGH_ONE_CYC || hi_len == HIGH_ZERO_CYC)
    else $error("downlink high time wrong");
  a_high_max: assert property (hi_len <= HIGH_ONE_CYC)
    else $error("downlink high too long");
  a_bit_period: assert property ($rose(dl) && seen |-> since == BIT_CYC)
    else $error("bit period wrong");
  a_resume_gap: assert property ($rose(dl) && !seen |-> lo_len >= BIT_CYC - HIGH_ZERO_CYC)
    else $error("resume gap too short");
  a_rise_hold: assert property ($rose(dl) |-> dl[*5])
    else $error("high phase too short");
  a_fall_hold: assert property ($fell(dl) |-> !dl[*5])
    else $error("low phase too short");
  a_up_stable: assert property (dl && $past(dl) |-> $stable(uplink_current_signal))
    else $error("uplink moved while downlink high");
  a_idle_runs: assert property (seen |-> since <= BIT_CYC)
    else $error("bits stopped");
  c_one_bit: cover property ($fell(dl) && hi_len == HIGH_ONE_CYC);
  c_zero_bit: cover property ($fell(dl) && hi_len == HIGH_ZERO_CYC);
  c_up_high: cover property (dl && uplink_current_signal);
endmodule
